// ==== inc/gp8_map.svh ====
// register offsets, field positions and reset values of the gpio port
`ifndef GP8_MAP_SVH
`define GP8_MAP_SVH

// address width of the configuration register port
`define GP8_ADDR_W 12
// byte offset of the pin data register
`define GP8_DATA_OFS 12'h434
// byte offset of the pin control register
`define GP8_CTRL_OFS 12'h438

// control register field positions
`define GP8_DIR_LSB 0
`define GP8_DIR_MSB 7
`define GP8_PULL_EN_LSB 8
`define GP8_PULL_EN_MSB 15
`define GP8_POL_LSB 16
`define GP8_POL_MSB 23
`define GP8_RESERVED_BITS_LSB 24
`define GP8_RESERVED_BITS_MSB 31

// reset values
`define GP8_CTRL_RST 32'h0000_0000
`define GP8_DATA_RST 8'h00

`endif

// ==== inc/gp8_pkg.sv ====
// types shared by the gpio port files
package gp8_pkg;

	// which register an access addresses
	typedef enum logic [1:0] {
		GP8_SEL_NONE = 2'b00,
		GP8_SEL_DATA = 2'b01,
		GP8_SEL_CTRL = 2'b10
	} gp8_sel_t;

	// one bit per pin
	typedef logic [7:0] gp8_pins_t;

endpackage : gp8_pkg

// ==== rtl/gp8_sync.sv ====
// two-stage level synchronizer for the pin inputs
`timescale 1ns/1ps

module gp8_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// width must be at least one bit
	initial begin
		if (WIDTH < 1) begin
			$error("gp8_sync: WIDTH must be at least 1");
		end
	end

	// first stage only feeds the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : gp8_sync

// ==== rtl/gp8_port.sv ====
// eight-pin general purpose port with data and control registers
`timescale 1ns/1ps
`include "gp8_map.svh"

//
// Contract
// RL1 - data register bits 7:0 carry one value per pin.
// RL2 - data writes only change pins that are currently outputs.
// RL3 - reading an output pin's bit returns its last written value.
// RL4 - direction comes only from control register bits 7:0.
// RL5 - control register resets to zero; software writes zero to 31:24.
// RL6 - direction bit zero makes the pin input, one makes it output.
// RL7 - bits 15:8 select normal mode or weak pull mode per pin.
// RL8 - bits 23:16 choose pull polarity: zero down, one up.
// RL9 - weak pull acts only when mode bit and direction bit are both one.
// RL10 - a data bit of zero means low, one means high.
// RL11 - input levels pass a two-stage synchronizer before being read.
// RL12 - data bits written for input pins are dropped, not retained.
module gp8_port #(
	parameter int PINS = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`GP8_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe_n,
	output logic [PINS-1:0] pin_pull_up,
	output logic [PINS-1:0] pin_pull_down
);

	import gp8_pkg::*;

	// the register layout fixes the port at exactly eight pins
	initial begin
		if (PINS != 8) begin
			$error("gp8_port: PINS must be 8 to match the register layout");
		end
		if (`GP8_DIR_MSB - `GP8_DIR_LSB + 1 != PINS) begin
			$error("gp8_port: direction field width differs from PINS");
		end
		if (`GP8_PULL_EN_MSB - `GP8_PULL_EN_LSB + 1 != PINS) begin
			$error("gp8_port: pull mode field width differs from PINS");
		end
		if (`GP8_POL_MSB - `GP8_POL_LSB + 1 != PINS) begin
			$error("gp8_port: polarity field width differs from PINS");
		end
	end

	// decode an address into a register select
	function automatic gp8_sel_t sel_of(
		input logic [`GP8_ADDR_W-1:0] addr
	);
		gp8_sel_t sel;
		sel = GP8_SEL_NONE;
		if (addr == `GP8_DATA_OFS) begin
			sel = GP8_SEL_DATA;
		end else if (addr == `GP8_CTRL_OFS) begin
			sel = GP8_SEL_CTRL;
		end
		return sel;
	endfunction : sel_of

	// per bit choose a when mask is one, else b
	function automatic logic [PINS-1:0] pick(
		input logic [PINS-1:0] mask,
		input logic [PINS-1:0] a,
		input logic [PINS-1:0] b
	);
		return (mask & a) | (~mask & b);
	endfunction : pick

	// control fields
	logic [PINS-1:0] pin_direction_q;
	logic [PINS-1:0] pin_weak_pull_enable_q;
	logic [PINS-1:0] pin_pull_polarity_q;

	// driven output levels
	logic [PINS-1:0] out_level_q;
	logic [PINS-1:0] out_level_d;

	// synchronized pin levels
	logic [PINS-1:0] in_level;

	// decoded access selects
	gp8_sel_t wr_sel;
	gp8_sel_t rd_sel;
	logic data_wr;
	logic ctrl_wr;

	// read path
	logic [PINS-1:0] pin_level_bit;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic rvalid_q;

	// pull qualification
	logic [PINS-1:0] pull_active;

	// decode writes and reads
	assign wr_sel = sel_of(reg_addr);
	assign rd_sel = sel_of(reg_addr);
	assign data_wr = reg_wr && (wr_sel == GP8_SEL_DATA);
	assign ctrl_wr = reg_wr && (wr_sel == GP8_SEL_CTRL);

	// input pins cross into the register clock through two flops
	gp8_sync #(
		.WIDTH(PINS)
	) u_in_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(pin_in),
		.sync_out(in_level) // RL11
	);

	// direction field, bits 7:0 of the control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_direction_q <= '0; // RL5
		end else if (ctrl_wr) begin
			pin_direction_q <= reg_wdata[`GP8_DIR_MSB:`GP8_DIR_LSB]; // RL4 RL6
		end
	end

	// weak pull mode field, bits 15:8
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_weak_pull_enable_q <= '0; // RL5
		end else if (ctrl_wr) begin
			pin_weak_pull_enable_q <=
				reg_wdata[`GP8_PULL_EN_MSB:`GP8_PULL_EN_LSB]; // RL7
		end
	end

	// pull polarity field, bits 23:16
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_pull_polarity_q <= '0; // RL5
		end else if (ctrl_wr) begin
			pin_pull_polarity_q <=
				reg_wdata[`GP8_POL_MSB:`GP8_POL_LSB]; // RL8
		end
	end

	// bits 31:24 are not stored; they always read as zero

	// data write merges only into bits of output pins
	always_comb begin
		out_level_d = out_level_q;
		if (data_wr) begin
			out_level_d = pick(pin_direction_q, reg_wdata[PINS-1:0],
				out_level_q); // RL2 RL12
		end
	end

	// driven level register, one bit per pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_level_q <= `GP8_DATA_RST;
		end else begin
			out_level_q <= out_level_d; // RL1
		end
	end

	// pin drive: level from register, enable low while driving
	assign pin_out = out_level_q; // RL10
	assign pin_oe_n = ~pin_direction_q; // RL6

	// weak pull needs both mode and output direction
	assign pull_active = pin_weak_pull_enable_q & pin_direction_q; // RL9
	assign pin_pull_up = pull_active & pin_pull_polarity_q; // RL8
	assign pin_pull_down = pull_active & ~pin_pull_polarity_q; // RL8

	// outputs read back the written value, inputs the pin level
	assign pin_level_bit = pick(pin_direction_q, out_level_q,
		in_level); // RL3 RL10

	// read data selection; unmapped addresses read zero
	// a read in the cycle of a write sees the state before that write
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (rd_sel)
			GP8_SEL_DATA: begin
				rdata_d[PINS-1:0] = pin_level_bit; // RL1
			end
			GP8_SEL_CTRL: begin
				rdata_d[`GP8_DIR_MSB:`GP8_DIR_LSB] = pin_direction_q;
				rdata_d[`GP8_PULL_EN_MSB:`GP8_PULL_EN_LSB] =
					pin_weak_pull_enable_q;
				rdata_d[`GP8_POL_MSB:`GP8_POL_LSB] = pin_pull_polarity_q;
			end
			default: begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// read data register, loaded on each read strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end
	end

	// read valid pulse, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;

endmodule : gp8_port

// ==== bench/gp8_port_assertions.sv ====
// checker for the gpio port register and pin behaviour
`timescale 1ns/1ps
module gp8_port_chk #(
	parameter int PINS = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] pin_oe_n,
	input wire logic [PINS-1:0] pin_pull_up,
	input wire logic [PINS-1:0] pin_pull_down
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] w_q;
	// write data of the previous edge
	always_ff @(posedge clk) w_q <= reg_wdata;
	sequence cw; reg_wr && reg_addr == 12'h438; endsequence
	sequence dw; reg_wr && reg_addr == 12'h434; endsequence
	AST_RVALID: assert property (reg_rvalid == $past(reg_rd))
		else $error("read answer timing wrong");
	AST_DIR: assert property (cw |=> pin_oe_n == ~w_q[7:0])
		else $error("direction not taken from control");
	AST_DIR_HOLD: assert property
		(!(reg_wr && reg_addr == 12'h438) |=> $stable(pin_oe_n))
		else $error("direction changed without control write");
	AST_PU: assert property (cw |=> pin_pull_up ==
		(w_q[7:0] & w_q[15:8] & w_q[23:16])) else $error("pull up wrong");
	AST_PD: assert property (cw |=> pin_pull_down ==
		(w_q[7:0] & w_q[15:8] & ~w_q[23:16])) else $error("pull down wrong");
	AST_PULL_OFF: assert property
		(((pin_pull_up | pin_pull_down) & pin_oe_n) == 8'h00)
		else $error("pull active on input pin");
	AST_DOUT: assert property
		(dw |=> ((pin_out ^ w_q[7:0]) & ~pin_oe_n) == 8'h00)
		else $error("output pin level not written");
	AST_DHOLD: assert property
		(!(reg_wr && reg_addr == 12'h434) |=> $stable(pin_out))
		else $error("pin level changed without data write");
	AST_DIN_DROP: assert property
		(dw |=> ((pin_out ^ $past(pin_out)) & pin_oe_n) == 8'h00)
		else $error("input pin bit took written data");
	AST_RESERVED_BITS: assert property (reg_rd && reg_addr == 12'h438
		|=> reg_rdata[31:24] == 8'h00) else $error("reserved bits read set");
endmodule : gp8_port_chk

// ==== bench/gp8_board.sv ====
// board model: pins loop back when driven, else follow outside level
`timescale 1ns/1ps
module gp8_board (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_in
);
	// driven pins show the port level, released ones the outside level
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : gp8_board

// ==== bench/gp8_port_tb.sv ====
// self-checking bench for the gpio port
`timescale 1ns/1ps
module gp8_port_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic reg_rvalid;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
	logic [7:0] pin_in, pin_out, pin_oe_n, pu, pd, ext = 8'h5a;
	int mismatches = 0, checks_done = 0, cyc = 0;
	always #12.5 clk = ~clk;
	gp8_port dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pu),
		.pin_pull_down(pd));
	gp8_board brd_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_level(ext), .pin_in(pin_in));
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		#2 reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clk);
		#2 reg_wr = 1'b0;
	endtask : wr
	task rd(input logic [11:0] a);
		@(posedge clk);
		#2 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#2 reg_rd = 1'b0;
		d = reg_rdata;
		chk({31'h0, reg_rvalid}, 32'h1);
	endtask : rd
	task t_reset;
		rd(12'h438);
		chk(d, 32'h0);
		chk({24'h0, pin_oe_n}, 32'hff);
		$display("test done: reset");
	endtask : t_reset
	task t_ctrl;
		wr(12'h438, 32'h00a53c0f);
		rd(12'h438);
		chk(d, 32'h00a53c0f);
		chk({pu, pd, pin_oe_n}, 24'h0408f0);
		$display("test done: control");
	endtask : t_ctrl
	task t_data;
		wr(12'h434, 32'hff);
		chk({24'h0, pin_out}, 32'h0f);
		rd(12'h434);
		chk({24'h0, d[7:0]}, 32'h5f);
		wr(12'h438, 32'hff);
		chk({24'h0, pin_out}, 32'h0f);
		$display("test done: data");
	endtask : t_data
	task t_input;
		wr(12'h438, 32'h0);
		ext = 8'ha5;
		rd(12'h430);
		chk(d, 32'h0);
		rd(12'h434);
		chk({24'h0, d[7:0]}, 32'ha5);
		$display("test done: input");
	endtask : t_input
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	// cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			summarize();
		end
	end
	// reset, then the scenarios
	initial begin
		repeat (6) @(posedge clk);
		#2 rst_n = 1'b1;
		t_reset();
		t_ctrl();
		t_data();
		t_input();
		summarize();
	end
endmodule : gp8_port_tb
bind gp8_port gp8_port_chk #(.PINS(PINS)) chk_u (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
	.pin_pull_down(pin_pull_down));
